//--- shared/prio_regs_pkg.sv
// Package with offsets, fields and reset values of the input priority registers
package prio_regs_pkg;
    localparam int        ADDR_WIDTH            = 7;
    localparam int        DATA_WIDTH            = 8;
    localparam int        FIELD_WIDTH           = 4;
    // Register offsets
    localparam logic [6:0] OFFS_PRIO_ELEVEN_TWELVE     = 7'h1D;
    localparam logic [6:0] OFFS_PRIO_THIRTEEN_FOURTEEN = 7'h1E;
    localparam logic [6:0] OFFS_SOURCE_SELECT          = 7'h4B;
    // Field positions
    localparam int        ODD_FIELD_LSB         = 0;
    localparam int        EVEN_FIELD_LSB        = 4;
    localparam int        PATH_VIEW_BIT         = 4;
    // Reset values
    localparam logic [7:0] RST_MAIN_ELEVEN_TWELVE     = 8'hDC;
    localparam logic [7:0] RST_MAIN_THIRTEEN_FOURTEEN = 8'hFE;
    localparam logic [7:0] RST_AUX_PRIO               = 8'h00;
    localparam logic [7:0] RST_SOURCE_SELECT          = 8'h00;
    // Input eleven main-path default by strap, and the unavailable code
    localparam logic [3:0] PRIO_ELEVEN_MASTER = 4'hC;
    localparam logic [3:0] PRIO_ELEVEN_SLAVE  = 4'h1;
    localparam logic [3:0] PRIO_UNAVAILABLE   = 4'h0;
endpackage

//--- src/prio_field_decode.sv
// Decode of one priority nibble into availability and rank
`timescale 1ns/1ps
module prio_field_decode (
    // Field in
    input  wire logic [prio_regs_pkg::FIELD_WIDTH-1:0] field,
    // Decoded
    output logic                                       available,
    output logic [prio_regs_pkg::FIELD_WIDTH-1:0]      rank
);
    import prio_regs_pkg::*;

    // Zero excludes the input; rank passes through unchanged otherwise
    always_comb begin
        available = (field != PRIO_UNAVAILABLE);
        rank      = field;
    end
endmodule // prio_field_decode

//--- src/ref_input_priority_regs.sv
// Priority registers for reference inputs eleven to fourteen, two path sets
// What this block does
// - Two RW nibbles: odd low, even high
// - Zero means unavailable; 1-15 are ranks
// - Input eleven main default: master 12, slave 1
// - Select bit 4 zero picks main path
// - Resets: main DC/FE, auxiliary 00/00
// - Thirteen/fourteen register follows eleven/twelve
`timescale 1ns/1ps
module ref_input_priority_regs (
    // Clock and reset
    input  wire logic                                  clock,
    input  wire logic                                  rst,
    // Strap
    input  wire logic                                  master_slave_strap_pin,
    // Microprocessor port
    input  wire logic [prio_regs_pkg::ADDR_WIDTH-1:0]  addr,
    input  wire logic                                  wr_en,
    input  wire logic                                  rd_en,
    input  wire logic [prio_regs_pkg::DATA_WIDTH-1:0]  wr_data,
    output logic      [prio_regs_pkg::DATA_WIDTH-1:0]  rd_data,
    // Priorities toward the selection engine, inputs 11..14
    output logic      [4*prio_regs_pkg::FIELD_WIDTH-1:0] main_rank,
    output logic      [3:0]                            main_available,
    output logic      [4*prio_regs_pkg::FIELD_WIDTH-1:0] aux_rank,
    output logic      [3:0]                            aux_available
);
    import prio_regs_pkg::*;

    logic [7:0] main_lo_q;    // Inputs eleven/twelve, main path
    logic [7:0] main_hi_q;    // Inputs thirteen/fourteen, main path
    logic [7:0] aux_lo_q;
    logic [7:0] aux_hi_q;
    logic [7:0] select_q;
    logic       strap_pending_q;
    logic       path_view_select_bit;
    logic       hit_lo;
    logic       hit_hi;
    logic [15:0] main_flat;
    logic [15:0] aux_flat;

    // Elaboration guards: the register map assumes two nibbles per byte
    // and an address bus wide enough for the source select offset. A
    // different package setting would silently mis-place fields, so it is
    // refused here instead.
    if (DATA_WIDTH != 2 * FIELD_WIDTH) begin : g_bad_width
        $error("priority byte must hold exactly two fields");
    end
    if (ADDR_WIDTH < 7) begin : g_bad_addr
        $error("address bus too narrow for the register map");
    end
    if (EVEN_FIELD_LSB != ODD_FIELD_LSB + FIELD_WIDTH) begin : g_bad_field
        $error("even field must sit directly above the odd field");
    end
    if (PATH_VIEW_BIT >= DATA_WIDTH) begin : g_bad_view
        $error("path view bit lies outside the select byte");
    end

    // The path view bit steers every priority access; both sets stay
    // visible to the selection engine at all times, whatever the view
    assign path_view_select_bit = select_q[PATH_VIEW_BIT];
    assign hit_lo = (addr == OFFS_PRIO_ELEVEN_TWELVE);
    assign hit_hi = (addr == OFFS_PRIO_THIRTEEN_FOURTEEN);

    // Strap is caught after reset release, not under it
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_pending_q <= 1'b1;
        end else begin
            strap_pending_q <= 1'b0;
        end
    end

    // Main path set; strap only overrides the eleven nibble once
    always_ff @(posedge clock) begin
        if (rst) begin
            main_lo_q <= RST_MAIN_ELEVEN_TWELVE;
            main_hi_q <= RST_MAIN_THIRTEEN_FOURTEEN;
        end else begin
            if (strap_pending_q) begin
                main_lo_q[ODD_FIELD_LSB +: FIELD_WIDTH] <=
                    master_slave_strap_pin ? PRIO_ELEVEN_MASTER
                                           : PRIO_ELEVEN_SLAVE;
            end
            // A write in the strap cycle wins over the default
            if (wr_en && !path_view_select_bit && hit_lo) begin
                main_lo_q <= wr_data;
            end
            if (wr_en && !path_view_select_bit && hit_hi) begin
                main_hi_q <= wr_data;
            end
        end
    end

    // Auxiliary set, untouched by main-path writes
    always_ff @(posedge clock) begin
        if (rst) begin
            aux_lo_q <= RST_AUX_PRIO;
            aux_hi_q <= RST_AUX_PRIO;
        end else begin
            if (wr_en && path_view_select_bit && hit_lo) begin
                aux_lo_q <= wr_data;
            end
            if (wr_en && path_view_select_bit && hit_hi) begin
                aux_hi_q <= wr_data;
            end
        end
    end

    // Source select register holding the path view bit
    always_ff @(posedge clock) begin
        if (rst) begin
            select_q <= RST_SOURCE_SELECT;
        end else if (wr_en && addr == OFFS_SOURCE_SELECT) begin
            select_q <= wr_data;
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            if (hit_lo) begin
                rd_data <= path_view_select_bit ? aux_lo_q : main_lo_q;
            end else if (hit_hi) begin
                rd_data <= path_view_select_bit ? aux_hi_q : main_hi_q;
            end else if (addr == OFFS_SOURCE_SELECT) begin
                rd_data <= select_q;
            end else begin
                rd_data <= 8'h00;
            end
        end
    end

    assign main_flat = {main_hi_q, main_lo_q};
    assign aux_flat  = {aux_hi_q, aux_lo_q};

    // One decoder per input and path
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_field
            prio_field_decode u_main (
                .field     (main_flat[gi*FIELD_WIDTH +: FIELD_WIDTH]),
                .available (main_available[gi]),
                .rank      (main_rank[gi*FIELD_WIDTH +: FIELD_WIDTH])
            );
            prio_field_decode u_aux (
                .field     (aux_flat[gi*FIELD_WIDTH +: FIELD_WIDTH]),
                .available (aux_available[gi]),
                .rank      (aux_rank[gi*FIELD_WIDTH +: FIELD_WIDTH])
            );
        end
    endgenerate
endmodule // ref_input_priority_regs

//--- sim/prio_regs_assertions.sv
// Checker for the input priority registers
`timescale 1ns/1ps
module prio_chk (
    input wire logic        clock, rst, master_slave_strap_pin, wr_en, rd_en,
    input wire logic [6:0]  addr,
    input wire logic [7:0]  wr_data, rd_data,
    input wire logic [15:0] main_rank, aux_rank,
    input wire logic [3:0]  main_available, aux_available
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic view_q; // Own copy of the path view bit
    always_ff @(posedge clock)
        view_q <= rst ? 1'b0 : (wr_en && addr == 7'h4B) ? wr_data[4] : view_q;
    sequence w_main; wr_en && addr == 7'h1D && !view_q; endsequence
    chk_main_write: assert property (w_main |=>
        main_rank[7:0] == $past(wr_data)) else $error("main write");
    chk_path_apart: assert property (w_main |=> $stable(aux_rank))
        else $error("aux disturbed");
    chk_aux_write: assert property (wr_en && addr == 7'h1E && view_q |=>
        aux_rank[15:8] == $past(wr_data)) else $error("aux write");
    chk_read_next: assert property (rd_en && addr == 7'h1E && !view_q |=>
        rd_data == $past(main_rank[15:8])) else $error("read back");
    chk_strap_default: assert property ($fell(rst) && !wr_en |=>
        main_rank[3:0] == ($past(master_slave_strap_pin) ? 4'hC : 4'h1))
        else $error("strap default");
    chk_zero_off: assert property (main_available[0] == |main_rank[3:0]
        && aux_available[3] == |aux_rank[15:12]) else $error("availability");
    // Reset is checked while it is held, so the default disable is overridden
    chk_reset_value: assert property (disable iff (1'b0) $past(rst) |->
        main_rank == 16'hFEDC && aux_rank == 16'h0) else $error("reset value");
endmodule // prio_chk
bind ref_input_priority_regs prio_chk u_chk (.clock, .rst,
    .master_slave_strap_pin, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
    .main_rank, .aux_rank, .main_available, .aux_available);

//--- sim/tb_top.sv
// Self-checking bench for the input priority registers
`timescale 1ns/1ps
module tb_top;
    logic        clock = 0, rst = 1, strap = 1, wr_en = 0, rd_en = 0;
    logic [6:0]  addr = 0;
    logic [7:0]  wr_data = 0, rd_data, sel, mm [2], aa [2];
    logic [15:0] main_rank, aux_rank;
    logic [3:0]  main_av, aux_av;
    logic [31:0] lf = 32'h8E3B1994;
    int          errors = 0, comparisons = 0;
    ref_input_priority_regs dut (.clock, .rst, .master_slave_strap_pin(strap),
        .addr, .wr_en, .rd_en, .wr_data, .rd_data, .main_rank, .aux_rank,
        .main_available(main_av), .aux_available(aux_av));
    initial forever #2.5 clock = ~clock;
    // Next random word; taps give a maximal-length sequence
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Model availability: a zero nibble takes the input out of selection
    function automatic logic [3:0] avail(logic [15:0] r);
        return {|r[15:12], |r[11:8], |r[7:4], |r[3:0]};
    endfunction
    // Model read: view bit picks the set, unmapped reads give zero
    function automatic logic [7:0] ex(logic [6:0] a);
        if (a == 7'h4B) return sel;
        if (a inside {7'h1D, 7'h1E}) return sel[4] ? aa[a[1]] : mm[a[1]];
        return 8'h00;
    endfunction
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(negedge clock) {addr, wr_data, wr_en} = {a, d, 1'b1};
        @(negedge clock) wr_en = 0;
        if (a == 7'h4B) sel = d;
        else if (a inside {7'h1D, 7'h1E} && sel[4]) aa[a[1]] = d;
        else if (a inside {7'h1D, 7'h1E}) mm[a[1]] = d;
        cmp({main_rank, aux_rank}, {mm[1], mm[0], aa[1], aa[0]});
        cmp({main_av, aux_av}, {avail({mm[1], mm[0]}), avail({aa[1], aa[0]})});
    endtask
    task automatic rd(logic [6:0] a);
        @(negedge clock) {addr, rd_en} = {a, 1'b1};
        @(negedge clock) rd_en = 0;
        cmp({24'h0, rd_data}, {24'h0, ex(a)});
    endtask
    // Reset held eight cycles; strap default lands one edge after release
    task automatic do_reset(logic s);
        @(negedge clock) {rst, strap} = {1'b1, s};
        repeat (8) @(negedge clock);
        rst = 0;
        {sel, aa[0], aa[1], mm[1], mm[0]} = {24'h0, 8'hFE, s ? 8'hDC : 8'hD1};
        @(negedge clock);
        cmp({main_rank, aux_rank}, {mm[1], mm[0], 16'h0});
        cmp({main_av, aux_av}, {avail({mm[1], mm[0]}), 4'h0});
        $display("reset test done, strap %0d", s);
    endtask
    task automatic results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        do_reset(1);
        for (int i = 0; i < 80; i++) begin
            lf = lfsr(lf);
            case (lf[1:0])
                2'd0: wr(7'h4B, lf[15:8]);
                2'd1: wr(lf[2] ? 7'h1E : 7'h1D, lf[15:8]);
                2'd2: rd(lf[3] ? 7'h4B : lf[2] ? 7'h1E : 7'h1D);
                default: rd(lf[14:8]);
            endcase
        end
        $display("random access test done");
        do_reset(0);
        wr(7'h1D, 8'h00);
        $display("zero priority test done");
        results();
    end
    // Watchdog well past the expected run length
    initial begin
        #20000;
        errors++;
        results();
    end
endmodule // tb_top
